// ==== hw/imcs_master.sv ====
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - reload value from 8-bit register; buffer write starts counter
// - counter counts to zero and halts; clock line keeps last level
// - counter decrements on second and fourth quarter phases
// - serial clock period is one low and one high counter period
// - counter pauses until released clock line is sampled high
// - after clock high, reload from low seven bits and count
// - start: both lines high, count, then drive data low, set start seen
// - after data low, one more period, clear start request, hold data low
// - start collision: both low at begin, or clock low early; abort
// - buffer write during start is dropped and sets write collision
// - low five control bits ignored while start or restart runs
// - restart: pull clock low, load low six bits, release data
// - at timeout with data high release clock; both high one period
// - data low one period, clear restart request without reload
// - start seen set on detection; event flag after final timeout
// - restart request ignored while another event is in progress
// - restart collision: data low on clock rise, or clock falls early
// - buffer write during restart is dropped and sets write collision
// - buffer write sets full flag; bits shift after clock falling edge
// - eighth clock fall clears full flag and releases data line
// - ninth clock fall samples ack into ack status flag
// - after ninth clock set event flag, halt holding clock low
// - buffer write while shifting sets write collision; software clears it
module imcs_master
(
  // clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // axi4-lite write address, data and response
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // open-drain bus lines
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out
);
  typedef struct packed
  {
    imcs_pkg::imcs_state_type st;
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic scl_f;
    logic sda_f;
    logic [1:0] phase;
    logic [7:0] cnt;
    logic run;
    logic [7:0] reload;
    logic [7:0] buffer;
    logic [7:0] shifter;
    logic [3:0] bitnum;
    logic start_req;
    logic restart_req;
    logic [2:0] other_ctrl;
    logic ack_status;
    logic buf_full;
    logic start_seen;
    logic write_collision_flag;
    logic bcol;
    logic event_flag;
    logic scl_low;
    logic sda_low;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } imcs_regs_type;

  imcs_regs_type r_ff;
  imcs_regs_type nxt_r;
  logic tick;
  logic timeout;
  logic wr_fire;
  logic busy;
  logic ctrl_wr;
  logic buf_wr;
  logic [7:0] rd_status;
  logic [7:0] rd_ctrl;

  // open-drain: output value is always low, enable pulls the line
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = r_ff.scl_low;
  assign sda_oe_out = r_ff.sda_low;
  assign s_axi_awready_out = !r_ff.aw_got && !r_ff.bvalid;
  assign s_axi_wready_out = !r_ff.w_got && !r_ff.bvalid;
  assign s_axi_bvalid_out = r_ff.bvalid;
  assign s_axi_bresp_out = r_ff.bresp;
  assign s_axi_arready_out = !r_ff.rvalid;
  assign s_axi_rvalid_out = r_ff.rvalid;
  assign s_axi_rdata_out = r_ff.rdata;
  assign s_axi_rresp_out = r_ff.rresp;

  assign tick = (r_ff.phase == imcs_pkg::PHASE_Q2) || (r_ff.phase == imcs_pkg::PHASE_Q4);
  assign timeout = r_ff.run && (r_ff.cnt == 8'h00);
  assign busy = (r_ff.st != imcs_pkg::ST_IDLE);
  assign wr_fire = r_ff.aw_got && r_ff.w_got && !r_ff.bvalid;
  assign ctrl_wr = wr_fire && (r_ff.awaddr == imcs_pkg::ADDR_CTRL2) && r_ff.wstrb[0];
  assign buf_wr = wr_fire && (r_ff.awaddr == imcs_pkg::ADDR_BUFFER) && r_ff.wstrb[0];

  always_comb
  begin
    rd_ctrl = {1'b0, r_ff.ack_status, 3'h0, r_ff.other_ctrl[0], r_ff.restart_req, r_ff.start_req};
    rd_ctrl[4:2] = r_ff.other_ctrl;
    rd_status = 8'h00;
    rd_status[imcs_pkg::STAT_BUF_FULL_BIT] = r_ff.buf_full;
    rd_status[imcs_pkg::STAT_START_SEEN_BIT] = r_ff.start_seen;
    rd_status[imcs_pkg::STAT_WRITE_COLLISION_FLAG_BIT] = r_ff.write_collision_flag;
    rd_status[imcs_pkg::STAT_BCOL_BIT] = r_ff.bcol;
    rd_status[imcs_pkg::STAT_EVENT_BIT] = r_ff.event_flag;
    rd_status[imcs_pkg::STAT_BUSY_BIT] = busy;
  end

  always_comb
  begin
    nxt_r = r_ff;
    // three-stage sampling; a change counts once stages two and three agree
    nxt_r.scl_sync = {r_ff.scl_sync[1:0], scl_in};
    nxt_r.sda_sync = {r_ff.sda_sync[1:0], sda_in};
    if (r_ff.scl_sync[1] == r_ff.scl_sync[2])
    begin
      nxt_r.scl_f = r_ff.scl_sync[2];
    end
    if (r_ff.sda_sync[1] == r_ff.sda_sync[2])
    begin
      nxt_r.sda_f = r_ff.sda_sync[2];
    end
    nxt_r.phase = r_ff.phase + 2'h1;
    // down-counter halts at zero until reloaded
    if (r_ff.run && tick && (r_ff.cnt != 8'h00))
    begin
      nxt_r.cnt = r_ff.cnt - 8'h01;
    end

    // axi write channel capture
    if (s_axi_awvalid_in && s_axi_awready_out)
    begin
      nxt_r.aw_got = 1'b1;
      nxt_r.awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out)
    begin
      nxt_r.w_got = 1'b1;
      nxt_r.wdata = s_axi_wdata_in;
      nxt_r.wstrb = s_axi_wstrb_in;
    end
    if (wr_fire)
    begin
      nxt_r.aw_got = 1'b0;
      nxt_r.w_got = 1'b0;
      nxt_r.bvalid = 1'b1;
      nxt_r.bresp = imcs_pkg::AXI_OKAY;
      unique case (r_ff.awaddr)
        imcs_pkg::ADDR_RELOAD:
        begin
          if (r_ff.wstrb[0])
          begin
            nxt_r.reload = r_ff.wdata[7:0];
          end
        end
        imcs_pkg::ADDR_BUFFER:
        begin
        end
        imcs_pkg::ADDR_CTRL2:
        begin
          // event bits only accepted while idle, no queueing
          if (ctrl_wr && !busy && !r_ff.start_req && !r_ff.restart_req)
          begin
            if (r_ff.wdata[imcs_pkg::CTRL_START_BIT])
            begin
              nxt_r.start_req = 1'b1;
            end
            else if (r_ff.wdata[imcs_pkg::CTRL_RESTART_BIT])
            begin
              nxt_r.restart_req = 1'b1;
            end
            nxt_r.other_ctrl = r_ff.wdata[4:2];
          end
        end
        imcs_pkg::ADDR_STATUS:
        begin
          // write one to clear sticky flags; a same-cycle set below wins
          if (r_ff.wstrb[0])
          begin
            if (r_ff.wdata[imcs_pkg::STAT_WRITE_COLLISION_FLAG_BIT])
            begin
              nxt_r.write_collision_flag = 1'b0;
            end
            if (r_ff.wdata[imcs_pkg::STAT_BCOL_BIT])
            begin
              nxt_r.bcol = 1'b0;
            end
            if (r_ff.wdata[imcs_pkg::STAT_EVENT_BIT])
            begin
              nxt_r.event_flag = 1'b0;
            end
            if (r_ff.wdata[imcs_pkg::STAT_START_SEEN_BIT])
            begin
              nxt_r.start_seen = 1'b0;
            end
          end
        end
        default:
        begin
          nxt_r.bresp = imcs_pkg::AXI_SLVERR;
        end
      endcase
    end
    if (r_ff.bvalid && s_axi_bready_in)
    begin
      nxt_r.bvalid = 1'b0;
    end
    if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      nxt_r.rvalid = 1'b1;
      nxt_r.rresp = imcs_pkg::AXI_OKAY;
      unique case (s_axi_araddr_in)
        imcs_pkg::ADDR_RELOAD: nxt_r.rdata = {24'h0, r_ff.reload};
        imcs_pkg::ADDR_BUFFER: nxt_r.rdata = {24'h0, r_ff.buffer};
        imcs_pkg::ADDR_CTRL2: nxt_r.rdata = {24'h0, rd_ctrl};
        imcs_pkg::ADDR_STATUS: nxt_r.rdata = {24'h0, rd_status};
        default:
        begin
          nxt_r.rdata = 32'h0;
          nxt_r.rresp = imcs_pkg::AXI_SLVERR;
        end
      endcase
    end
    else if (r_ff.rvalid && s_axi_rready_in)
    begin
      nxt_r.rvalid = 1'b0;
    end

    // buffer write: taken when idle, else dropped with collision
    if (buf_wr)
    begin
      if (busy || r_ff.start_req || r_ff.restart_req)
      begin
        nxt_r.write_collision_flag = 1'b1;
      end
      else
      begin
        nxt_r.buffer = r_ff.wdata[7:0];
        nxt_r.shifter = r_ff.wdata[7:0];
        nxt_r.buf_full = 1'b1;
        nxt_r.bitnum = 4'h0;
        nxt_r.scl_low = 1'b1;
        nxt_r.sda_low = !r_ff.wdata[7];
        nxt_r.cnt = r_ff.reload;
        nxt_r.run = 1'b1;
        nxt_r.st = imcs_pkg::ST_TX_LOW;
      end
    end

    unique case (r_ff.st)
      imcs_pkg::ST_IDLE:
      begin
        nxt_r.run = buf_wr ? nxt_r.run : 1'b0;
        if (r_ff.start_req)
        begin
          if (!r_ff.scl_f && !r_ff.sda_f)
          begin
            nxt_r.bcol = 1'b1;
            nxt_r.start_req = 1'b0;
          end
          else if (r_ff.scl_f && r_ff.sda_f)
          begin
            nxt_r.cnt = {1'b0, r_ff.reload[6:0]};
            nxt_r.run = 1'b1;
            nxt_r.st = imcs_pkg::ST_START_WAIT;
          end
        end
        else if (r_ff.restart_req)
        begin
          nxt_r.scl_low = 1'b1;
          nxt_r.st = imcs_pkg::ST_RS_LOW;
        end
      end
      imcs_pkg::ST_START_WAIT:
      begin
        // data held low by another party at timeout would otherwise stall the start
        if (!r_ff.scl_f || (timeout && !r_ff.sda_f))
        begin
          nxt_r.bcol = 1'b1;
          nxt_r.start_req = 1'b0;
          nxt_r.run = 1'b0;
          nxt_r.st = imcs_pkg::ST_IDLE;
        end
        else if (timeout && r_ff.sda_f)
        begin
          nxt_r.sda_low = 1'b1;
          nxt_r.start_seen = 1'b1;
          nxt_r.cnt = {1'b0, r_ff.reload[6:0]};
          nxt_r.st = imcs_pkg::ST_START_HOLD;
        end
      end
      imcs_pkg::ST_START_HOLD:
      begin
        if (timeout)
        begin
          nxt_r.start_req = 1'b0;
          nxt_r.event_flag = 1'b1;
          nxt_r.run = 1'b0;
          nxt_r.st = imcs_pkg::ST_IDLE;
        end
      end
      imcs_pkg::ST_RS_LOW:
      begin
        if (!r_ff.scl_f)
        begin
          nxt_r.cnt = {2'h0, r_ff.reload[5:0]};
          nxt_r.run = 1'b1;
          nxt_r.sda_low = 1'b0;
          nxt_r.st = imcs_pkg::ST_RS_SDA_UP;
        end
      end
      imcs_pkg::ST_RS_SDA_UP:
      begin
        if (timeout && r_ff.sda_f)
        begin
          nxt_r.scl_low = 1'b0;
          nxt_r.run = 1'b0;
          nxt_r.st = imcs_pkg::ST_RS_SCL_REL;
        end
      end
      imcs_pkg::ST_RS_SCL_REL:
      begin
        // wait for a possible stretch
        if (r_ff.scl_f)
        begin
          if (!r_ff.sda_f)
          begin
            nxt_r.bcol = 1'b1;
            nxt_r.restart_req = 1'b0;
            nxt_r.st = imcs_pkg::ST_IDLE;
          end
          else
          begin
            nxt_r.cnt = {1'b0, r_ff.reload[6:0]};
            nxt_r.run = 1'b1;
            nxt_r.st = imcs_pkg::ST_RS_HIGH;
          end
        end
      end
      imcs_pkg::ST_RS_HIGH:
      begin
        if (!r_ff.scl_f || !r_ff.sda_f)
        begin
          nxt_r.bcol = 1'b1;
          nxt_r.restart_req = 1'b0;
          nxt_r.run = 1'b0;
          nxt_r.st = imcs_pkg::ST_IDLE;
        end
        else if (timeout)
        begin
          nxt_r.sda_low = 1'b1;
          nxt_r.start_seen = 1'b1;
          nxt_r.cnt = {1'b0, r_ff.reload[6:0]};
          nxt_r.st = imcs_pkg::ST_RS_HOLD;
        end
      end
      imcs_pkg::ST_RS_HOLD:
      begin
        if (timeout)
        begin
          nxt_r.restart_req = 1'b0;
          nxt_r.event_flag = 1'b1;
          nxt_r.run = 1'b0;
          nxt_r.st = imcs_pkg::ST_IDLE;
        end
      end
      imcs_pkg::ST_TX_LOW:
      begin
        // low half of a bit: one counter period
        if (timeout)
        begin
          nxt_r.scl_low = 1'b0;
          nxt_r.run = 1'b0;
          nxt_r.st = imcs_pkg::ST_TX_REL;
        end
      end
      imcs_pkg::ST_TX_REL:
      begin
        if (r_ff.scl_f)
        begin
          nxt_r.cnt = {1'b0, r_ff.reload[6:0]};
          nxt_r.run = 1'b1;
          nxt_r.st = imcs_pkg::ST_TX_HIGH;
        end
      end
      imcs_pkg::ST_TX_HIGH:
      begin
        if (timeout)
        begin
          nxt_r.scl_low = 1'b1;
          nxt_r.bitnum = r_ff.bitnum + 4'h1;
          nxt_r.cnt = r_ff.reload;
          nxt_r.st = imcs_pkg::ST_TX_LOW;
          if (r_ff.bitnum + 4'h1 == imcs_pkg::BITS_PER_BYTE)
          begin
            nxt_r.buf_full = 1'b0;
            nxt_r.sda_low = 1'b0;
          end
          else if (r_ff.bitnum + 4'h1 == imcs_pkg::ACK_BIT_NUM)
          begin
            nxt_r.ack_status = r_ff.sda_f;
            nxt_r.event_flag = 1'b1;
            nxt_r.run = 1'b0;
            nxt_r.st = imcs_pkg::ST_IDLE;
          end
          else
          begin
            nxt_r.shifter = {r_ff.shifter[6:0], 1'b0};
            nxt_r.sda_low = !r_ff.shifter[6];
          end
        end
      end
      default:
      begin
        nxt_r.st = imcs_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      r_ff <= '0;
      r_ff.st <= imcs_pkg::ST_IDLE;
      r_ff.reload <= imcs_pkg::RELOAD_RESET;
      r_ff.scl_sync <= 3'h7;
      r_ff.sda_sync <= 3'h7;
      r_ff.scl_f <= 1'b1;
      r_ff.sda_f <= 1'b1;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end
endmodule // imcs_master
`default_nettype wire

// ==== hw/imcs_pkg.sv ====
`default_nettype none
package imcs_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_RELOAD = 8'h00;
  localparam logic [7:0] ADDR_BUFFER = 8'h04;
  localparam logic [7:0] ADDR_CTRL2 = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  // control_reg_two fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam int CTRL_ACK_STATUS_BIT = 6;
  localparam logic [4:0] CTRL_EVENT_MASK = 5'h1f;
  // status_reg fields
  localparam int STAT_BUF_FULL_BIT = 0;
  localparam int STAT_START_SEEN_BIT = 3;
  localparam int STAT_WRITE_COLLISION_FLAG_BIT = 4;
  localparam int STAT_BCOL_BIT = 5;
  localparam int STAT_EVENT_BIT = 6;
  localparam int STAT_BUSY_BIT = 7;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  // a quarter phase lasts one clock: decrements fall on phases 1 and 3 of 0..3
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_BIT_NUM = 4'h9;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [10:0]
  {
    ST_IDLE = 11'h001,
    ST_START_WAIT = 11'h002,
    ST_START_HOLD = 11'h004,
    ST_RS_LOW = 11'h008,
    ST_RS_SDA_UP = 11'h010,
    ST_RS_SCL_REL = 11'h020,
    ST_RS_HIGH = 11'h040,
    ST_RS_HOLD = 11'h080,
    ST_TX_LOW = 11'h100,
    ST_TX_REL = 11'h200,
    ST_TX_HIGH = 11'h400
  } imcs_state_type;
endpackage
`default_nettype wire

// ==== sim/i2c_master_clock_start_transmit_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module i2c_master_clock_start_transmit_test;
  logic clock, nrst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, reload, got_byte;
  logic [31:0] wdata, rdata, rd_val, seed, tx;
  logic [1:0] bresp, rresp, rd_resp, wr_resp;
  logic scl_oe, sda_oe, slv_scl, slv_sda, tb_scl, tb_sda, ack_en;
  logic [2:0] stretch;
  int bad_count, checks;
  wire logic scl_line;
  wire logic sda_line;
  // pull-ups: a line is high unless some party pulls it low
  assign scl_line = !(scl_oe || slv_scl || tb_scl);
  assign sda_line = !(sda_oe || slv_sda || tb_sda);
  imcs_master dut_u (.clock_in(clock), .nrst_in(nrst), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .scl_in(scl_line),
    .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda_line), .sda_out(), .sda_oe_out(sda_oe));
  imcs_slave_model slave_u (.clock_in(clock), .nrst_in(nrst), .scl_line_in(scl_line), .sda_line_in(sda_line),
    .ack_en_in(ack_en), .stretch_in(stretch), .scl_pull_out(slv_scl), .sda_pull_out(slv_sda), .byte_out(got_byte));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] flag(input int b, input logic v);
    return {31'h0, v} << b;
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // signals change just after a rising edge; handshakes are judged from values that the next edge samples
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t, busy;
    busy = 1'b1;
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    while (busy)
    begin
      @(negedge clock);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid && bready;
      wr_resp = bresp;
      @(posedge clock);
      if (aw_t)
        awvalid <= 1'b0;
      if (w_t)
        wvalid <= 1'b0;
      if (b_t)
        bready <= 1'b0;
      busy = !b_t;
    end
    // one edge between transfers, so bready is never lowered and raised in one step
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar_t, r_t, busy;
    busy = 1'b1;
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    while (busy)
    begin
      @(negedge clock);
      ar_t = arvalid && arready;
      r_t = rvalid && rready;
      rd_val = rdata;
      rd_resp = rresp;
      @(posedge clock);
      if (ar_t)
        arvalid <= 1'b0;
      if (r_t)
        rready <= 1'b0;
      busy = !r_t;
    end
    @(posedge clock);
  endtask
  task automatic chk_bit(input string name, input logic [7:0] a, input int b, input logic exp);
    rd(a);
    check(name, rd_val & flag(b, 1'b1), flag(b, exp));
  endtask
  task automatic wait_flag(input int b);
    rd(imcs_pkg::ADDR_STATUS);
    while (rd_val[b] !== 1'b1)
      rd(imcs_pkg::ADDR_STATUS);
  endtask
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
  endtask
  initial
  begin
    clock = 1'b0;
    forever
      #20 clock = ~clock;
  end
  initial
  begin
    repeat (40000) @(posedge clock);
    bad_count++;
    end_of_test();
  end
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, tb_scl, tb_sda} = '0;
    {awaddr, araddr, wdata, stretch, ack_en} = '0;
    seed = 32'h5e8e;
    do_reset();
    rd(imcs_pkg::ADDR_RELOAD);
    check("reload reset", rd_val, {24'h0, imcs_pkg::RELOAD_RESET});
    rd(8'h10);
    check("unmapped data", rd_val, 32'h0);
    check("unmapped resp", {30'h0, rd_resp}, {30'h0, imcs_pkg::AXI_SLVERR});
    wr(8'h10, 32'h0);
    check("unmapped wresp", {30'h0, wr_resp}, {30'h0, imcs_pkg::AXI_SLVERR});
    $display("register test done");
    // long start phase so the queued writes land inside it
    wr(imcs_pkg::ADDR_RELOAD, 32'h0c);
    check("write resp", {30'h0, wr_resp}, {30'h0, imcs_pkg::AXI_OKAY});
    wr(imcs_pkg::ADDR_CTRL2, 32'h1);
    wr(imcs_pkg::ADDR_BUFFER, 32'ha5);
    wr(imcs_pkg::ADDR_CTRL2, 32'h2);
    wait_flag(imcs_pkg::STAT_START_SEEN_BIT);
    rd(imcs_pkg::ADDR_CTRL2);
    while (rd_val[imcs_pkg::CTRL_START_BIT] !== 1'b0)
      rd(imcs_pkg::ADDR_CTRL2);
    check("restart ignored", rd_val & 32'h3, 32'h0);
    check("start lines", {30'h0, scl_line, sda_line}, 32'h2);
    chk_bit("start write_collision_flag", imcs_pkg::ADDR_STATUS, imcs_pkg::STAT_WRITE_COLLISION_FLAG_BIT, 1'b1);
    wr(imcs_pkg::ADDR_STATUS, 32'h78);
    chk_bit("write_collision_flag cleared", imcs_pkg::ADDR_STATUS, imcs_pkg::STAT_WRITE_COLLISION_FLAG_BIT, 1'b0);
    $display("start test done");
    reload = 8'h2 + 8'(rnd() % 32'h4);
    wr(imcs_pkg::ADDR_RELOAD, {24'h0, reload});
    for (int i = 0; i < 6; i++)
    begin
      tx = rnd();
      if (i < 2)
        tx[7:0] = {8{i[0]}};
      ack_en <= tx[8];
      stretch <= tx[11:9];
      wr(imcs_pkg::ADDR_BUFFER, {24'h0, tx[7:0]});
      chk_bit("full set", imcs_pkg::ADDR_STATUS, imcs_pkg::STAT_BUF_FULL_BIT, 1'b1);
      if (i == 0)
        wr(imcs_pkg::ADDR_BUFFER, {24'h0, ~tx[7:0]});
      wait_flag(imcs_pkg::STAT_EVENT_BIT);
      check("byte", {24'h0, got_byte}, {24'h0, tx[7:0]});
      chk_bit("ack status", imcs_pkg::ADDR_CTRL2, imcs_pkg::CTRL_ACK_STATUS_BIT, !tx[8]);
      chk_bit("full clear", imcs_pkg::ADDR_STATUS, imcs_pkg::STAT_BUF_FULL_BIT, 1'b0);
      chk_bit("write_collision_flag", imcs_pkg::ADDR_STATUS, imcs_pkg::STAT_WRITE_COLLISION_FLAG_BIT, i == 0);
      check("clock held low", {31'h0, scl_line}, 32'h0);
      wr(imcs_pkg::ADDR_STATUS, 32'h78);
    end
    $display("transmit test done");
    wr(imcs_pkg::ADDR_CTRL2, 32'h2);
    wait_flag(imcs_pkg::STAT_EVENT_BIT);
    chk_bit("restart cleared", imcs_pkg::ADDR_CTRL2, imcs_pkg::CTRL_RESTART_BIT, 1'b0);
    chk_bit("restart seen", imcs_pkg::ADDR_STATUS, imcs_pkg::STAT_START_SEEN_BIT, 1'b1);
    check("restart lines", {30'h0, scl_line, sda_line}, 32'h2);
    $display("restart test done");
    for (int m = 0; m < 2; m++)
    begin
      tb_scl <= (m == 0);
      tb_sda <= (m == 0);
      do_reset();
      wr(imcs_pkg::ADDR_RELOAD, 32'h0c);
      wr(imcs_pkg::ADDR_CTRL2, 32'h1);
      tb_scl <= 1'b1;
      wait_flag(imcs_pkg::STAT_BCOL_BIT);
      check("abort released", {30'h0, scl_oe, sda_oe}, 32'h0);
      chk_bit("abort idle", imcs_pkg::ADDR_CTRL2, imcs_pkg::CTRL_START_BIT, 1'b0);
    end
    $display("collision test done");
    end_of_test();
  end
endmodule // i2c_master_clock_start_transmit_test
`default_nettype wire

// ==== sim/imcs_master_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module imcs_master_assertions
(
  // clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // register bus handshakes
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // bus lines
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_out,
  input wire logic sda_out,
  input wire logic sda_oe_out
);
  logic wr_take;
  assign wr_take = s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);
  AST_SCL_NOT_DRIVEN: assert property (scl_out == 1'b0)
    else $error("clock line driven high");
  AST_SDA_NOT_DRIVEN: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  // bench reload is two or more, so each phase spans at least three clocks
  AST_LOW_PHASE: assert property ($rose(scl_oe_out) |-> scl_oe_out [*3])
    else $error("clock low phase too short");
  AST_HIGH_PHASE: assert property ($fell(scl_oe_out) |-> !scl_oe_out [*3])
    else $error("clock high phase too short");
  AST_STRETCH_PAUSE: assert property (!scl_oe_out && !scl_in |=> !scl_oe_out)
    else $error("clock pulled while line still held low");
  AST_DATA_AFTER_FALL: assert property ($fell(sda_oe_out) |-> scl_oe_out)
    else $error("data released while clock high");
  AST_BVALID_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("write response dropped early");
  AST_WRITE_ANSWER: assert property (wr_take |-> ##[1:3] s_axi_bvalid_out)
    else $error("write response missing");
  COV_START: cover property ($rose(sda_oe_out) && !scl_oe_out);
  COV_STRETCH: cover property (!scl_oe_out && !scl_in);
  COV_WRITE: cover property (s_axi_bvalid_out && s_axi_bready_in);
endmodule // imcs_master_assertions
bind imcs_master imcs_master_assertions chk_u (.clock_in, .nrst_in, .s_axi_awvalid_in, .s_axi_awready_out,
  .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in, .scl_in, .scl_out, .scl_oe_out,
  .sda_out, .sda_oe_out);
`default_nettype wire

// ==== sim/imcs_slave_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module imcs_slave_model
(
  // clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // wire levels
  input wire logic scl_line_in,
  input wire logic sda_line_in,
  // behaviour
  input wire logic ack_en_in,
  input wire logic [2:0] stretch_in,
  // pulls and received byte
  output logic scl_pull_out,
  output logic sda_pull_out,
  output logic [7:0] byte_out
);
  logic scl_q, sda_q;
  logic [3:0] count;
  logic [7:0] shift;
  logic [2:0] hold;
  always_ff @(posedge clock_in)
  begin
    scl_q <= scl_line_in;
    sda_q <= sda_line_in;
    if (!nrst_in)
    begin
      count <= 4'h0;
      hold <= 3'h0;
      scl_pull_out <= 1'b0;
      sda_pull_out <= 1'b0;
    end
    else if (scl_q && scl_line_in && sda_q && !sda_line_in)
      count <= 4'h0;
    else if (!scl_q && scl_line_in && count < 4'h9)
    begin
      if (count < 4'h8)
        shift <= {shift[6:0], sda_line_in};
      count <= count + 4'h1;
    end
    else if (scl_q && !scl_line_in)
    begin
      // stretching every low phase makes the master wait on the line
      hold <= stretch_in;
      scl_pull_out <= (stretch_in != 3'h0);
      if (count == 4'h8)
        sda_pull_out <= ack_en_in;
      if (count == 4'h9)
      begin
        sda_pull_out <= 1'b0;
        byte_out <= shift;
        count <= 4'h0;
      end
    end
    else if (hold != 3'h0)
    begin
      hold <= hold - 3'h1;
      scl_pull_out <= (hold != 3'h1);
    end
  end
endmodule // imcs_slave_model
`default_nettype wire
